// ===== core/twm_top.sv
// 8-bit timer wave-mode control: apb registers, counter, two outputs
// assumes an apb master on core_clk_in and port data from the same clock
// assumes one answer per setup, no wait state, no byte strobes
// limitation: counter steps every clock, no prescaler
//
// Behaviour
// RULE_01 - nonzero action field puts compare output on pin
// RULE_02 - pin driver enabled only by direction bit
// RULE_03 - out a non-pwm: off, toggle, clear, set
// RULE_04 - out a fast pwm actions, toggle needs high bit
// RULE_05 - out a phase pwm actions, toggle needs high bit
// RULE_06 - compare equal top: ignore match, act at top
// RULE_07 - out b non-pwm: off, toggle, clear, set
// RULE_08 - out b fast pwm actions, action 1 reserved
// RULE_09 - out b phase pwm actions, action 1 reserved
// RULE_10 - bits 3 and 2 ignore writes, read zero
// RULE_11 - mode from two low bits plus high bit
// RULE_12 - normal top max, match mode top a, immediate
// RULE_13 - phase modes buffer at top, overflow at bottom
// RULE_14 - fast modes buffer at top, overflow max or top
// RULE_15 - software never selects mode 4 or 6
// RULE_16 - high mode bit at ctrl b bit 3
// RULE_17 - bottom is zero, all fields reset zero
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module twm_top
	import twm_pkg::*;
(
	input  wire logic        core_clk_in,   // timer and bus clock, 50 MHz
	input  wire logic        rst_b_in,      // sync reset, low
	input  wire logic        psel_in,       // apb select
	input  wire logic        penable_in,    // apb enable
	input  wire logic        pwrite_in,     // apb direction
	input  wire logic [11:0] paddr_in,      // apb byte address
	input  wire logic [31:0] pwdata_in,     // apb write data
	input  wire logic [1:0]  port_data_in,  // normal port function per pin
	output logic      [31:0] prdata_out,    // apb read data
	output logic             pready_out,    // apb ready
	output logic             pslverr_out,   // apb error on unmapped
	output logic      [1:0]  pin_val_out,   // pin level, bit0 a bit1 b
	output logic      [1:0]  pin_oe_b_out,  // pin driver enable, low drives
	output logic             overflow_out   // overflow_flag level
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]  act_a;    // out_a_action
		logic [1:0]  act_b;    // out_b_action
		logic [1:0]  wlow;     // wave_mode_low
		logic        whigh;    // wave_mode_high
		logic [2:0]  csel;     // clock select, nonzero runs
		logic [7:0]  buf_a;    // compare_value_a as written
		logic [7:0]  buf_b;    // compare_value_b as written
		logic [7:0]  cmp_a;    // compare a in use when buffered
		logic [7:0]  cmp_b;    // compare b in use when buffered
		logic [7:0]  cnt;      // counter
		logic        down;     // phase pwm down slope
		logic        ovf;      // overflow_flag
		logic [1:0]  dir;      // pin direction bits
		logic [31:0] prdata;   // read data
		logic        pready;   // ready
		logic        pslverr;  // error
		logic [1:0]  pin_val;  // pin level
		logic [1:0]  pin_oe_b; // pin enable, low
	} twm_state_t;
	twm_state_t s_reg, s_next;
	// ----------------------------------------
	// pin ownership
	// ----------------------------------------
	// nonzero action takes the pin, except action 1 in pwm:
	// channel a without the high bit stays on its port,
	// channel b keeps the pin and holds its level
	function automatic logic twm_connected(input logic [1:0] act, input logic pwm_mode, input logic high,
		input logic is_b);
		logic off; // action 1 falls back to the port
		off = pwm_mode & (act == 2'h1) & ~high & ~is_b;
		return (act != 2'h0) & ~off;
	endfunction : twm_connected

	// ----------------------------------------
	// decode and datapath wires
	// ----------------------------------------
	twm_mode_if m_if ();            // decoded mode
	twm_mode_t  mode;               // wave_mode_field
	twm_idx_t   idx;                // register hit
	logic [7:0] eff_a;              // compare a as compared
	logic [7:0] eff_b;              // compare b as compared
	logic [7:0] top;                // current top
	logic       run;                // counter running
	logic       at_top;             // counter at top
	logic       match_a, match_b;   // compare matches
	logic       oc_a, oc_b;         // channel levels
	logic       wr;                 // write taken this edge
	logic       setup;              // setup cycle
	logic       ovf_set;            // overflow event
	logic [7:0] cnt_plus, cnt_minus;
	logic       pwm_any;            // either pwm mode
	logic       conn_a, conn_b;     // compare output owns the pin

	// mode bits live in two registers,
	// so they are joined once here
	assign mode  = twm_mode_t'({s_reg.whigh, s_reg.wlow}); // RULE_11
	assign idx   = twm_decode(paddr_in);
	assign setup = psel_in & ~penable_in;
	// write lands only in the access cycle that pready marks
	assign wr    = psel_in & penable_in & s_reg.pready & pwrite_in;
	// non-buffered modes compare against the written value at once
	assign eff_a = m_if.buffered ? s_reg.cmp_a : s_reg.buf_a; // RULE_12
	assign eff_b = m_if.buffered ? s_reg.cmp_b : s_reg.buf_b;
	assign top   = m_if.top_is_a ? eff_a : TWM_MAX; // RULE_12 RULE_13 RULE_14
	assign run   = s_reg.csel != 3'h0;
	assign at_top  = run & (s_reg.cnt == top);
	assign match_a = run & (s_reg.cnt == eff_a);
	assign match_b = run & (s_reg.cnt == eff_b);
	assign cnt_plus  = s_reg.cnt + 8'h01;
	assign cnt_minus = s_reg.cnt - 8'h01;

	// pin owner per channel, decoded once
	// for the pin mux; the checks decode it themselves
	assign pwm_any = m_if.fast | m_if.phase;
	assign conn_a  = twm_connected(s_reg.act_a, pwm_any, m_if.high, 1'b0); // RULE_01 RULE_04 RULE_05
	assign conn_b  = twm_connected(s_reg.act_b, pwm_any, m_if.high, 1'b1); // RULE_01 RULE_08 RULE_09

	// ----------------------------------------
	// mode decoder and channels
	// ----------------------------------------
	twm_mode_dec u_dec (
		.mode_in (mode),
		.m_out   (m_if)
	);
	// channel a: pwm toggle allowed with high bit
	twm_chan #(.IS_B(1'b0)) u_chan_a (
		.core_clk_in   (core_clk_in),
		.rst_b_in      (rst_b_in),
		.m_in          (m_if),
		.action_in     (s_reg.act_a),
		.match_in      (match_a),
		.at_top_in     (at_top),
		.up_in         (~s_reg.down),
		.cmp_is_top_in (eff_a == top),
		.oc_out        (oc_a)
	);
	// channel b: pwm action 1 holds the level
	twm_chan #(.IS_B(1'b1)) u_chan_b (
		.core_clk_in   (core_clk_in),
		.rst_b_in      (rst_b_in),
		.m_in          (m_if),
		.action_in     (s_reg.act_b),
		.match_in      (match_b),
		.at_top_in     (at_top),
		.up_in         (~s_reg.down),
		.cmp_is_top_in (eff_b == top),
		.oc_out        (oc_b)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next  = s_reg;
		ovf_set = 1'b0;
		// counter sequence per mode
		// phase modes climb to top and fall back,
		// the others climb and wrap to bottom
		if (run) begin
			if (m_if.phase) begin // RULE_13
				if (!s_reg.down) begin
					// turn at top, but a zero top never turns
					if (at_top && s_reg.cnt != TWM_BOTTOM) begin
						s_next.down = 1'b1;
						s_next.cnt  = cnt_minus;
					end else begin
						s_next.cnt = cnt_plus;
					end
				// down slope ends at bottom: turn, flag
				end else if (s_reg.cnt == TWM_BOTTOM) begin // RULE_17
					s_next.down = 1'b0;
					s_next.cnt  = cnt_plus;
					ovf_set     = 1'b1;
				end else begin
					s_next.cnt = cnt_minus;
				end
			end else begin
				s_next.down = 1'b0;
				s_next.cnt  = at_top ? TWM_BOTTOM : cnt_plus; // RULE_12 RULE_14
				// overflow at max, or at top in fast mode 7
				ovf_set = m_if.ovf_at_max ? (s_reg.cnt == TWM_MAX) : at_top; // RULE_12 RULE_14
			end
		end
		// buffered compare values load at top
		if (!m_if.buffered || at_top) begin // RULE_13 RULE_14
			s_next.cmp_a = s_reg.buf_a;
			s_next.cmp_b = s_reg.buf_b;
		end
		// register writes
		// a counter write follows the step, so software wins
		if (wr) begin
			unique case (idx)
				// bits 3:2 are never stored
				TWM_I_CTRL_A: begin // RULE_10
					s_next.act_a = pwdata_in[TWM_ACT_A_LSB +: 2];
					s_next.act_b = pwdata_in[TWM_ACT_B_LSB +: 2];
					s_next.wlow  = pwdata_in[1:0];
				end
				// bits 7:4 are not stored and read zero
				TWM_I_CTRL_B: begin // RULE_16
					s_next.whigh = pwdata_in[TWM_WHIGH_BIT];
					s_next.csel  = pwdata_in[2:0];
				end
				TWM_I_CMP_A:   s_next.buf_a = pwdata_in[7:0];
				TWM_I_CMP_B:   s_next.buf_b = pwdata_in[7:0];
				TWM_I_COUNT:   s_next.cnt   = pwdata_in[7:0];
				TWM_I_STATUS:  ; // flag clear handled below
				TWM_I_PIN_DIR: s_next.dir   = pwdata_in[1:0];
				TWM_I_NONE:    ; // ignored, error reported
			endcase
		end
		// overflow flag: write one clears, a new event wins
		s_next.ovf = (s_reg.ovf & ~(wr & idx == TWM_I_STATUS & pwdata_in[0])) | ovf_set;
		// apb answer prepared in setup, valid for the access cycle
		// reads sample the register one cycle before pready
		s_next.pready  = setup;
		s_next.pslverr = setup & (idx == TWM_I_NONE);
		s_next.prdata  = 32'h0000_0000;
		if (setup && !pwrite_in) begin
			unique case (idx)
				TWM_I_CTRL_A:  s_next.prdata[7:0] = {s_reg.act_a, s_reg.act_b, 2'h0, s_reg.wlow}; // RULE_10
				TWM_I_CTRL_B:  s_next.prdata[7:0] = {4'h0, s_reg.whigh, s_reg.csel}; // RULE_16
				TWM_I_CMP_A:   s_next.prdata[7:0] = s_reg.buf_a;
				TWM_I_CMP_B:   s_next.prdata[7:0] = s_reg.buf_b;
				TWM_I_COUNT:   s_next.prdata[7:0] = s_reg.cnt;
				TWM_I_STATUS:  s_next.prdata[0]   = s_reg.ovf;
				TWM_I_PIN_DIR: s_next.prdata[1:0] = s_reg.dir;
				TWM_I_NONE:    s_next.prdata      = 32'h0000_0000;
			endcase
		end
		// pin mux: compare output or normal port value
		// registered, so the pin never glitches mid-cycle
		s_next.pin_val[0] = conn_a ? oc_a : port_data_in[0]; // RULE_01 RULE_04
		s_next.pin_val[1] = conn_b ? oc_b : port_data_in[1]; // RULE_01
		// driver follows direction alone, whoever owns the pin
		s_next.pin_oe_b   = ~s_reg.dir; // RULE_02
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// one register for all state keeps next-state in one place
	// all fields zero except pin_oe_b, all ones: normal mode, outputs disconnected, drivers off
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin // RULE_17
			s_reg          <= '0;
			s_reg.pin_oe_b <= 2'h3;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// every output straight from a flip-flop
	assign prdata_out   = s_reg.prdata;
	assign pready_out   = s_reg.pready;
	assign pslverr_out  = s_reg.pslverr;
	assign pin_val_out  = s_reg.pin_val;
	assign pin_oe_b_out = s_reg.pin_oe_b;
	assign overflow_out = s_reg.ovf;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// bus: no wait state, answer stands one cycle
	a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
		else $error("pready not a single cycle after setup");
	// reserved control bits never reach read data
	a_ctrl_a_rsvd_zero: assert property (setup && !pwrite_in && idx == TWM_I_CTRL_A |=> prdata_out[3:2] == 2'h0) // RULE_10
		else $error("reserved control bits read nonzero");

	// pin a on its port while action a is zero
	a_pin_port_pass: assert property (s_reg.act_a == 2'h0 |=> pin_val_out[0] == $past(port_data_in[0])) // RULE_01
		else $error("pin a not following port data");
	// pin b taken by any nonzero action
	a_pin_override_b: assert property (s_reg.act_b != 2'h0 |=> pin_val_out[1] == $past(oc_b)) // RULE_01
		else $error("pin b not showing compare output");
	// pwm toggle without high bit leaves pin a alone
	a_pin_a_discon: assert property (pwm_any && s_reg.act_a == 2'h1 && !m_if.high // RULE_04
		|=> pin_val_out[0] == $past(port_data_in[0]))
		else $error("pin a not released for pwm toggle without high bit");
	// pin a driver turns on after its direction bit rises
	a_pin_drive_dir: assert property ($rose(s_reg.dir[0]) |=> !pin_oe_b_out[0]) // RULE_02
		else $error("pin a driver not enabled by direction");
	// both drivers track direction every cycle
	a_pin_oe_dir: assert property (1'b1 |=> pin_oe_b_out == ~$past(s_reg.dir)) // RULE_02
		else $error("pin drivers not following direction bits");

	// normal mode wraps at max and flags
	a_normal_wrap_ovf: assert property (run && mode == TWM_NORMAL && s_reg.cnt == TWM_MAX && !wr // RULE_12
		|=> s_reg.cnt == TWM_BOTTOM && overflow_out)
		else $error("normal mode wrap or overflow wrong");
	// phase modes turn at bottom and flag
	a_phase_bottom_ovf: assert property (run && m_if.phase && s_reg.down && s_reg.cnt == TWM_BOTTOM && !wr // RULE_13
		|=> !s_reg.down && s_reg.cnt == 8'h01 && overflow_out)
		else $error("phase mode bottom turn wrong");
	// mode 7 wraps, loads and flags at top
	a_fast_top_load: assert property (run && mode == TWM_FAST_A && at_top && !wr // RULE_14
		|=> s_reg.cnt == TWM_BOTTOM && s_reg.cmp_a == $past(s_reg.buf_a) && overflow_out)
		else $error("fast mode 7 top handling wrong");
	// an overflow event beats a same-cycle clear
	a_ovf_set_wins: assert property (ovf_set |=> overflow_out) // RULE_13
		else $error("overflow event lost to a clear");

	// clear action in match mode
	a_clear_oc_match: assert property (mode == TWM_CLEAR_ON_MATCH && s_reg.act_a == 2'h2 && match_a |=> !oc_a) // RULE_03
		else $error("clear on match did not clear output a");
	// reserved pwm action on b holds the level
	a_chan_b_hold: assert property (pwm_any && s_reg.act_b == 2'h1 |=> oc_b == $past(oc_b)) // RULE_08
		else $error("channel b moved on reserved pwm action");
	// control fields zero out of reset
	a_high_bit_reset: assert property ($rose(rst_b_in) |-> !s_reg.whigh && s_reg.act_a == 2'h0 && s_reg.act_b == 2'h0) // RULE_16
		else $error("control fields not zero after reset");

	// main scenarios seen
	c_phase_turn: cover property (m_if.phase && at_top ##[1:300] s_reg.cnt == TWM_BOTTOM);
	c_pin_a_discon: cover property (pwm_any && s_reg.act_a == 2'h1 && !m_if.high);
	c_fast_pwm_a: cover property (mode == TWM_FAST_A && s_reg.act_a == 2'h2 && match_a);
	c_unmapped: cover property (pslverr_out);
	c_ovf_clear_race: cover property (wr && idx == TWM_I_STATUS && ovf_set);
endmodule : twm_top

// ===== core/twm_pkg.sv
// constants, mode codes and address decode for the timer wave-mode block
// assumes a 32-bit apb slave with 12 address bits decoded
package twm_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] TWM_OFF_CTRL_A  = 12'h000; // wave control a
	localparam logic [11:0] TWM_OFF_CTRL_B  = 12'h004; // wave control b
	localparam logic [11:0] TWM_OFF_CMP_A   = 12'h008; // compare value a
	localparam logic [11:0] TWM_OFF_CMP_B   = 12'h00C; // compare value b
	localparam logic [11:0] TWM_OFF_COUNT   = 12'h010; // counter value
	localparam logic [11:0] TWM_OFF_STATUS  = 12'h014; // overflow flag
	localparam logic [11:0] TWM_OFF_PIN_DIR = 12'h018; // pin direction
	// ----------------------------------------
	// field positions and values
	// ----------------------------------------
	localparam int          TWM_ACT_A_LSB = 6;     // out_a_action
	localparam int          TWM_ACT_B_LSB = 4;     // out_b_action
	localparam int          TWM_WHIGH_BIT = 3;     // wave_mode_high in ctrl b
	localparam logic [7:0]  TWM_MAX       = 8'hFF; // counter max and fixed top
	localparam logic [7:0]  TWM_BOTTOM    = 8'h00; // counter bottom
	localparam logic [7:0]  TWM_RST_BYTE  = 8'h00; // reset of every field
	// ----------------------------------------
	// wave modes and register indices
	// ----------------------------------------
	typedef enum logic [2:0] {
		TWM_NORMAL = 3'b000, TWM_PHASE_FF = 3'b001, TWM_CLEAR_ON_MATCH = 3'b010, TWM_FAST_FF = 3'b011,
		TWM_RSV4 = 3'b100, TWM_PHASE_A = 3'b101, TWM_RSV6 = 3'b110, TWM_FAST_A = 3'b111
	} twm_mode_t;
	typedef enum logic [2:0] {
		TWM_I_CTRL_A = 3'h0, TWM_I_CTRL_B = 3'h1, TWM_I_CMP_A = 3'h2, TWM_I_CMP_B = 3'h3,
		TWM_I_COUNT = 3'h4, TWM_I_STATUS = 3'h5, TWM_I_PIN_DIR = 3'h6, TWM_I_NONE = 3'h7
	} twm_idx_t;
	// byte address to register index, none for unmapped
	function automatic twm_idx_t twm_decode(input logic [11:0] a);
		unique case (a)
			TWM_OFF_CTRL_A:  return TWM_I_CTRL_A;
			TWM_OFF_CTRL_B:  return TWM_I_CTRL_B;
			TWM_OFF_CMP_A:   return TWM_I_CMP_A;
			TWM_OFF_CMP_B:   return TWM_I_CMP_B;
			TWM_OFF_COUNT:   return TWM_I_COUNT;
			TWM_OFF_STATUS:  return TWM_I_STATUS;
			TWM_OFF_PIN_DIR: return TWM_I_PIN_DIR;
			default:         return TWM_I_NONE;
		endcase
	endfunction : twm_decode
endpackage : twm_pkg

// ===== core/twm_mode_if.sv
// decoded wave mode shared by decoder and channel units
// assumes one driver, the mode decoder
`timescale 1ns/1ps
interface twm_mode_if;
	logic fast;       // single-slope pwm
	logic phase;      // dual-slope pwm
	logic top_is_a;   // top from compare value a
	logic buffered;   // compare values load at top
	logic ovf_at_max; // overflow flag at max, else top or bottom
	logic high;       // wave_mode_high bit itself
	modport drv (output fast, phase, top_is_a, buffered, ovf_at_max, high);
	modport rcv (input fast, phase, top_is_a, buffered, ovf_at_max, high);
endinterface : twm_mode_if

// ===== core/twm_mode_dec.sv
// wave mode decoder: three mode bits to counting properties
// assumes mode bits come from registers on the same clock
`timescale 1ns/1ps
module twm_mode_dec
	import twm_pkg::*;
(
	input  wire twm_mode_t mode_in, // combined wave_mode_field
	twm_mode_if.drv        m_out    // decoded properties
);
	// reserved codes 4 and 6 fall back to normal counting
	always_comb begin
		m_out.high       = mode_in[2];
		m_out.fast       = 1'b0;
		m_out.phase      = 1'b0;
		m_out.top_is_a   = 1'b0;
		m_out.buffered   = 1'b0;
		m_out.ovf_at_max = 1'b1;
		unique case (mode_in)
			TWM_NORMAL, TWM_RSV4, TWM_RSV6: begin // RULE_12
			end
			TWM_CLEAR_ON_MATCH: m_out.top_is_a = 1'b1; // RULE_12
			TWM_PHASE_FF, TWM_PHASE_A: begin // RULE_13
				m_out.phase      = 1'b1;
				m_out.buffered   = 1'b1;
				m_out.ovf_at_max = 1'b0;
				m_out.top_is_a   = mode_in[2];
			end
			TWM_FAST_FF: begin // RULE_14
				m_out.fast     = 1'b1;
				m_out.buffered = 1'b1;
			end
			TWM_FAST_A: begin // RULE_14
				m_out.fast       = 1'b1;
				m_out.buffered   = 1'b1;
				m_out.top_is_a   = 1'b1;
				m_out.ovf_at_max = 1'b0;
			end
		endcase
	end
endmodule : twm_mode_dec

// ===== core/twm_chan.sv
// one compare output channel: action decode and output level
// assumes match, top and direction come from the counter on this clock
`timescale 1ns/1ps
module twm_chan
	import twm_pkg::*;
#(
	parameter logic IS_B = 1'b0 // channel b: action 1 reserved in pwm
) (
	input  wire logic       core_clk_in,   // timer clock
	input  wire logic       rst_b_in,      // sync reset, low
	twm_mode_if.rcv         m_in,          // decoded mode
	input  wire logic [1:0] action_in,     // output action field
	input  wire logic       match_in,      // counter equals compare
	input  wire logic       at_top_in,     // counter equals top
	input  wire logic       up_in,         // counting up
	input  wire logic       cmp_is_top_in, // compare equals top
	output logic            oc_out         // compare output level
);
	typedef struct packed {
		logic oc; // output level
	} twm_chan_state_t;
	twm_chan_state_t s_reg, s_next;
	logic            special; // match ignored, act at top
	logic            pwm;
	// next output level from action, mode and events
	always_comb begin
		s_next  = s_reg;
		pwm     = m_in.fast | m_in.phase;
		special = pwm & cmp_is_top_in & action_in[1]; // RULE_06
		if (!pwm) begin
			if (match_in) begin // RULE_03 RULE_07
				unique case (action_in)
					2'h0: s_next.oc = s_reg.oc;
					2'h1: s_next.oc = ~s_reg.oc;
					2'h2: s_next.oc = 1'b0;
					2'h3: s_next.oc = 1'b1;
				endcase
			end
		end else if (action_in == 2'h1) begin
			// toggle only on channel a with the high mode bit
			if (match_in && m_in.high && !IS_B) s_next.oc = ~s_reg.oc; // RULE_04 RULE_05 RULE_08 RULE_09
		end else if (action_in[1]) begin
			if (m_in.fast) begin // RULE_04 RULE_08
				if (match_in && !special) s_next.oc = action_in[0];
				if (at_top_in) s_next.oc = ~action_in[0];
			end else begin // RULE_05 RULE_09
				if (match_in && !special) s_next.oc = up_in ? action_in[0] : ~action_in[0];
				if (special && at_top_in) s_next.oc = ~action_in[0]; // RULE_06
			end
		end
	end
	// level register, low after reset
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) s_reg <= '0;
		else s_reg <= s_next;
	end
	assign oc_out = s_reg.oc;
endmodule : twm_chan

// ===== sim/test_twm_top.sv
// self-checking bench for the timer wave-mode block: registers, pins, pwm shapes, overflow
// assumes twm_pkg and twm_top are compiled first; one 50 MHz clock, apb driven here
`timescale 1ns/1ps
module test_twm_top
	import twm_pkg::*;
;
	// ----------------------------------------
	// clock, reset and design wires
	// ----------------------------------------
	logic        clk     = 1'b0;   // timer and bus clock
	logic        rst_b   = 1'b0;   // sync reset, low
	logic        psel    = 1'b0;   // apb select
	logic        penable = 1'b0;   // apb enable
	logic        pwrite  = 1'b0;   // apb direction
	logic [11:0] paddr   = 12'h000; // apb address
	logic [31:0] pwdata  = 32'h0;  // apb write data
	logic [1:0]  pd      = 2'h0;   // normal port values
	logic [31:0] prdata;           // apb read data
	logic        pready;           // apb ready
	logic        pslverr;          // apb error
	logic [1:0]  pin_val;          // pin levels
	logic [1:0]  pin_oe_b;         // pin drivers, low drives
	logic        ovf;              // overflow level
	int          failures  = 0;    // mismatches seen
	int          cmp_count = 0;    // comparisons made
	logic [7:0]  seed      = 8'h53; // lfsr state, fixed start
	logic [7:0]  x;                // random compare value
	logic [31:0] r;                // read scratch
	logic        e;                // error scratch

	// 20 ns period
	always #10 clk = ~clk;

	twm_top twm_top_i (.core_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .port_data_in(pd), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .pin_val_out(pin_val), .pin_oe_b_out(pin_oe_b),
		.overflow_out(ovf));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// 8-bit lfsr, taps 8 6 5 4 so no short cycle
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// verdict, reached from the end of the run or a stuck handshake
	task automatic final_report;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	// one compare for every kind of result, all widened to a word
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// apb transfer; pready read right after the edge is its sampled value
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, {24'h0, d}, rd, er);
	endtask : wreg

	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(nm, exp, rd);
	endtask : rchk

	// program a mode, let it settle two periods, then count high samples over two periods
	// compares go in while in normal mode so buffering cannot hold stale values
	task automatic run_pwm(input logic [2:0] md, input logic [1:0] aa, input logic [1:0] ab,
		input logic [7:0] ca, input logic [7:0] cb, input int per, input int ea, input int eb);
		int ha;
		int hb;
		wreg(TWM_OFF_CTRL_B, 8'h00);
		wreg(TWM_OFF_CTRL_A, 8'h00);
		wreg(TWM_OFF_CMP_A, ca);
		wreg(TWM_OFF_CMP_B, cb);
		wreg(TWM_OFF_COUNT, 8'h00);
		wreg(TWM_OFF_CTRL_A, {aa, ab, 2'b00, md[1:0]});
		wreg(TWM_OFF_CTRL_B, {4'h0, md[2], 3'b001});
		repeat (2 * per + 4) @(posedge clk);
		ha = 0;
		hb = 0;
		repeat (2 * per) begin
			@(posedge clk);
			ha += (pin_val[0] === 1'b1);
			hb += (pin_val[1] === 1'b1);
		end
		chk("high_a", ea, ha);
		chk("high_b", eb, hb);
	endtask : run_pwm

	// run a mode from zero with top a of 10 for some cycles, then read the flag
	task automatic ovf_case(input logic [2:0] md, input int cyc, input logic exp);
		wreg(TWM_OFF_CTRL_B, 8'h00);
		wreg(TWM_OFF_CTRL_A, 8'h00);
		wreg(TWM_OFF_CMP_A, 8'h0A);
		wreg(TWM_OFF_COUNT, 8'h00);
		wreg(TWM_OFF_STATUS, 8'h01);
		wreg(TWM_OFF_CTRL_A, {6'h00, md[1:0]});
		wreg(TWM_OFF_CTRL_B, {4'h0, md[2], 3'b001});
		repeat (cyc) @(posedge clk);
		wreg(TWM_OFF_CTRL_B, 8'h00);
		chk("overflow_pin", {31'h0, exp}, {31'h0, ovf});
		rchk("overflow", TWM_OFF_STATUS, {31'h0, exp});
	endtask : ovf_case

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk("oe_reset", 32'h3, {30'h0, pin_oe_b});
		rchk("ctrl_a_reset", TWM_OFF_CTRL_A, 32'h0);
		rchk("ctrl_b_reset", TWM_OFF_CTRL_B, 32'h0);
		// random register contents; counter kept stopped
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wreg(TWM_OFF_CTRL_A, seed);
			rchk("ctrl_a_rw", TWM_OFF_CTRL_A, {24'h0, seed & 8'hF3});
			wreg(TWM_OFF_CTRL_B, seed & 8'h08);
			rchk("ctrl_b_rw", TWM_OFF_CTRL_B, {24'h0, seed & 8'h08});
			wreg(TWM_OFF_PIN_DIR, {6'h00, seed[1:0]});
			repeat (2) @(posedge clk);
			chk("pin_oe", {30'h0, ~seed[1:0]}, {30'h0, pin_oe_b});
			wreg(TWM_OFF_CTRL_A, 8'h00);
			pd <= seed[3:2];
			repeat (3) @(posedge clk);
			chk("pin_port", {30'h0, seed[3:2]}, {30'h0, pin_val});
		end
		// unmapped place: error, write lost, reads zero
		apb(1'b1, 12'h01C, 32'hFFFFFFFF, r, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
		apb(1'b0, 12'h01C, 32'h0, r, e);
		chk("unmapped_rd", 32'h0, r);
		wreg(TWM_OFF_PIN_DIR, 8'h03);
		pd <= 2'b10;
		// match mode, top 5: toggle, clear, set on both channels
		for (int k = 1; k < 4; k++) begin
			run_pwm(3'd2, k[1:0], k[1:0], 8'h05, 8'h02, 6, (k == 1) ? 6 : (k == 3) ? 12 : 0,
				(k == 1) ? 6 : (k == 3) ? 12 : 0);
		end
		// fast pwm with top a; channel a compare equals top
		for (int k = 2; k < 4; k++) begin
			seed = lfsr(seed);
			x = seed % 19 + 1;
			run_pwm(3'd7, k[1:0], k[1:0], 8'd20, x, 21, (k == 2) ? 42 : 0,
				(k == 2) ? 2 * (x + 1) : 42 - 2 * (x + 1));
		end
		// mode 3, action 1 without high bit: pin a back on its port, which is high here; then mode 7 with high bit: pin a toggles
		pd <= 2'b11;
		run_pwm(3'd3, 2'd1, 2'd0, 8'd20, 8'd3, 8, 16, 16);
		run_pwm(3'd7, 2'd1, 2'd0, 8'd20, 8'd3, 21, 21, 42);
		// phase pwm with top a
		for (int k = 2; k < 4; k++) begin
			seed = lfsr(seed);
			x = seed % 19 + 1;
			run_pwm(3'd5, k[1:0], k[1:0], 8'd20, x, 40, (k == 2) ? 80 : 0,
				(k == 2) ? 4 * x : 4 * (20 - x));
		end
		// overflow point per mode
		ovf_case(3'd0, 40, 1'b0);
		ovf_case(3'd0, 300, 1'b1);
		ovf_case(3'd2, 40, 1'b0);
		ovf_case(3'd3, 40, 1'b0);
		ovf_case(3'd7, 15, 1'b1);
		ovf_case(3'd5, 30, 1'b1);
		ovf_case(3'd1, 530, 1'b1);
		wreg(TWM_OFF_STATUS, 8'h01);
		rchk("ovf_clear", TWM_OFF_STATUS, 32'h0);
		final_report();
	end
endmodule : test_twm_top
